// ===== nspf_pkg.sv
package nspf_pkg;
    // Packet identities and fixed lengths.
    localparam logic [7:0] ID_BASE = 8'h50;
    localparam logic [7:0] LEN_BASE = 8'h2D;
    localparam logic [7:0] ID_ZAV = 8'h53;
    localparam logic [7:0] LEN_ZAV = 8'h08;
    localparam logic [7:0] ID_SAT = 8'h54;
    localparam logic [7:0] HDR_SAT = 8'h02;
    localparam logic [7:0] REC_BYTES = 8'h09;
    localparam logic [7:0] REC_LAST = 8'h08;
    localparam logic [4:0] MAX_PER_PKT = 5'h1C;
    localparam logic [5:0] BASE_LAST = 6'h2C;
    localparam int NBASE = 11;
    // Satellite table depth; also the largest satellite count accepted.
    localparam logic [6:0] MAX_SATS = 7'h40;
    localparam logic [7:0] SYS_MAX = 8'h06;
    localparam logic [7:0] FREQ_MAX = 8'h0A;
    localparam logic [2:0] FIX_MAX = 3'h7;
    // Legal frequency codes per system, bit n set when code n is defined.
    localparam logic [6:0][10:0] FREQ_OK = {11'h16F, 11'h103, 11'h767, 11'h123,
                                            11'h16B, 11'h1FF, 11'h001};
    // Zero-angular-velocity byte positions inside the framed stream.
    localparam logic [3:0] ZAV_DUR0 = 4'h2;
    localparam logic [3:0] ZAV_RSV0 = 4'h6;
    localparam logic [3:0] ZAV_END = 4'h9;
    // Register byte addresses.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_ZAV = 8'h08;
    localparam logic [7:0] A_BASE0 = 8'h0C;
    localparam logic [7:0] A_FIX = 8'h38;
    localparam logic [7:0] A_SCNT = 8'h3C;
    localparam logic [7:0] A_SIDX = 8'h40;
    localparam logic [7:0] A_SATA = 8'h44;
    localparam logic [7:0] A_SATB = 8'h48;
    localparam logic [7:0] A_SATC = 8'h4C;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam int FIFO_W = 9;
    localparam int FIFO_D = 4;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ID = 2'b01, ST_LEN = 2'b11,
                              ST_PAY = 2'b10} nspf_st_t;
    // One satellite record, first transmitted byte in the low bits.
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] snr2;
        logic [7:0] snr1;
        logic [15:0] az;
        logic [7:0] elev;
        logic [7:0] freq;
        logic [7:0] prn;
        logic [7:0] sys;
    } nspf_rec_t;
endpackage

// ===== nspf_fifo.sv
`timescale 1ns/1ns
module nspf_fifo
#(
    parameter int W = 9,
    parameter int D = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic [D-1:0][W-1:0] m;
        logic [D-1:0] v;
    } nspf_fifo_t;

    nspf_fifo_t r_reg, r_next;
    logic placed;

    // A shift structure keeps the head in slot 0, so the outputs are flops.
    assign in_ready = !r_reg.v[D-1];
    assign out_valid = r_reg.v[0];
    assign out_data = r_reg.m[0];

    always_comb
    begin
        placed = 1'b0;
        r_next = r_reg;
        if (r_reg.v[0] && out_ready)
        begin
            for (int i = 0; i < D - 1; i++)
            begin
                r_next.m[i] = r_reg.m[i+1];
                r_next.v[i] = r_reg.v[i+1];
            end
            r_next.v[D-1] = 1'b0;
        end
        if (in_valid && in_ready)
        begin
            for (int i = 0; i < D; i++)
            begin
                if (!placed && !r_next.v[i])
                begin
                    r_next.m[i] = in_data;
                    r_next.v[i] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end
endmodule

// ===== nspf_rx.sv
`timescale 1ns/1ns
module nspf_rx
    import nspf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    input wire logic in_sop,
    input wire logic in_eop,
    input wire logic [7:0] in_data,
    output logic dur_stb,
    output logic [31:0] dur,
    output logic err_stb
);
    typedef struct packed {
        logic [3:0] idx;
        logic [7:0] id;
        logic [7:0] len;
        logic [31:0] dur;
        logic nz;
        logic stb;
        logic err;
    } nspf_rx_t;

    nspf_rx_t r_reg, r_next;
    logic [3:0] b;

    assign dur_stb = r_reg.stb;
    assign dur = r_reg.dur;
    assign err_stb = r_reg.err;

    always_comb
    begin
        r_next = r_reg;
        r_next.stb = 1'b0;
        r_next.err = 1'b0;
        b = in_sop ? 4'h0 : r_reg.idx;
        if (in_valid)
        begin
            if (in_sop)
                r_next.nz = 1'b0;
            if (b == 4'h0)
                r_next.id = in_data;
            if (b == 4'h1)
                r_next.len = in_data;
            if (b >= ZAV_DUR0 && b < ZAV_RSV0)
                r_next.dur[8*(b-ZAV_DUR0) +: 8] = in_data;
            if (b >= ZAV_RSV0 && b <= ZAV_END && in_data != 8'h00)
                r_next.nz = 1'b1;
            r_next.idx = (b == 4'hF) ? b : 4'(b + 4'h1);
            // Other packet identities pass by untouched.
            if (in_eop && r_next.id == ID_ZAV)
            begin
                if (r_next.len == LEN_ZAV && b == ZAV_END && !r_next.nz)
                    r_next.stb = 1'b1;
                else
                    r_next.err = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end
endmodule

// ===== nspf_top.sv
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Base report: id 80, length 45; seconds, microseconds, three doubles.
// - Relative north, east, down floats at payload bytes 32, 36, 40.
// - Payload byte 44 carries the fix status code 0 to 7.
// - Zero-velocity command id 83, length 8, duration float accepted.
// - Satellite report id 84, length two plus nine per satellite.
// - Byte 0 total reports in epoch, byte 1 sequence from 1.
// - Record: system, number, frequency, elevation, azimuth, two SNRs, flags.
// - No report holds more than 28 satellite records.
// - Large epochs span several reports, total above 1, sequence steps by one.
// - System codes 0 to 6 only; reserved codes read as unknown.
// - Frequency codes valid per constellation, others sent as unknown.
// - Flag bits 0 to 3 defined, bits 4 to 7 zero.
module nspf_top
    import nspf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic rx_sop,
    input wire logic rx_eop,
    input wire logic [7:0] rx_data,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready
);
    typedef struct packed {
        logic [NBASE-1:0][31:0] base;
        logic [2:0] fix;
        logic [6:0] scnt;
        logic [5:0] sidx;
        nspf_rec_t [int'(MAX_SATS)-1:0] sat;
        logic [31:0] zav;
        logic zav_new;
        logic zav_err;
        logic pend_base;
        logic pend_sat;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        nspf_st_t st;
        logic is_sat;
        logic [5:0] bcnt;
        logic [3:0] rj;
        logic [5:0] ridx;
        logic [4:0] pleft;
        logic [6:0] remain;
        logic [1:0] seq;
        logic [1:0] total;
    } nspf_state_t;

    nspf_state_t r_reg, r_next;
    logic [7:0] ob;
    logic olast;
    logic push;
    logic f_ready;
    logic [4:0] pn;
    logic [359:0] bpay;
    logic [7:0] boff;
    logic [7:0] fsys;
    logic setup;
    logic acc;
    logic zav_stb;
    logic zav_err_stb;
    logic [31:0] zav_dur;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a <= A_SATC);
    endfunction

    // Undefined codes for a constellation are sent as unknown rather than garbage.
    function automatic logic [7:0] freq_chk(input logic [2:0] s, input logic [7:0] f);
        if (f > FREQ_MAX)
            freq_chk = 8'h00;
        else
            freq_chk = FREQ_OK[s][f[3:0]] ? f : 8'h00;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    nspf_rx u_rx
    (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(rx_valid),
        .in_sop(rx_sop),
        .in_eop(rx_eop),
        .in_data(rx_data),
        .dur_stb(zav_stb),
        .dur(zav_dur),
        .err_stb(zav_err_stb)
    );

    nspf_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo
    (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(push),
        .in_data({olast, ob}),
        .in_ready(f_ready),
        .out_valid(tx_valid),
        .out_data({tx_last, tx_data}),
        .out_ready(tx_ready)
    );

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;

    //////////////////////////////////////////////////////////////////////////
    assign bpay = {5'h00, r_reg.fix, r_reg.base};
    assign pn = (r_reg.remain > 7'(MAX_PER_PKT)) ? MAX_PER_PKT : r_reg.remain[4:0];
    assign push = (r_reg.st != ST_IDLE) && f_ready;
    assign boff = paddr - A_BASE0;
    assign setup = psel && !penable;
    assign acc = psel && penable && r_reg.pready;
    assign fsys = (pwdata[7:0] > SYS_MAX) ? 8'h00 : pwdata[7:0];

    always_comb
    begin
        ob = 8'h00;
        olast = 1'b0;
        unique case (r_reg.st)
            ST_IDLE:
                ob = 8'h00;
            ST_ID:
                ob = r_reg.is_sat ? ID_SAT : ID_BASE;
            ST_LEN:
                ob = r_reg.is_sat ? 8'(HDR_SAT + 8'(pn) * REC_BYTES) : LEN_BASE;
            ST_PAY:
            begin
                if (!r_reg.is_sat)
                begin
                    ob = bpay[8*r_reg.bcnt +: 8];
                    olast = (r_reg.bcnt == BASE_LAST);
                end
                else if (r_reg.bcnt == 6'h00)
                    ob = {6'h00, r_reg.total};
                else if (r_reg.bcnt == 6'h01)
                begin
                    ob = {6'h00, r_reg.seq};
                    olast = (r_reg.pleft == 5'h00);
                end
                else
                begin
                    ob = r_reg.sat[r_reg.ridx][8*r_reg.rj +: 8];
                    olast = (r_reg.rj == REC_LAST[3:0]) && (r_reg.pleft == 5'h01);
                end
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        r_next = r_reg;
        // Register slave: data is fetched in the setup cycle, so every access
        // completes with no wait state.
        r_next.pready = setup;
        if (setup)
        begin
            r_next.pslverr = !addr_ok(paddr);
            r_next.prdata = RST_WORD;
            if (paddr == A_CTRL)
                r_next.prdata = {30'h0, r_reg.pend_sat, r_reg.pend_base};
            else if (paddr == A_STAT)
                r_next.prdata = {29'h0, r_reg.zav_err, r_reg.zav_new, r_reg.st != ST_IDLE};
            else if (paddr == A_ZAV)
                r_next.prdata = r_reg.zav;
            else if (paddr >= A_BASE0 && paddr < A_FIX)
                r_next.prdata = r_reg.base[boff[5:2]];
            else if (paddr == A_FIX)
                r_next.prdata = {29'h0, r_reg.fix};
            else if (paddr == A_SCNT)
                r_next.prdata = {25'h0, r_reg.scnt};
            else if (paddr == A_SIDX)
                r_next.prdata = {26'h0, r_reg.sidx};
            else if (paddr == A_SATA)
                r_next.prdata = r_reg.sat[r_reg.sidx][31:0];
            else if (paddr == A_SATB)
                r_next.prdata = r_reg.sat[r_reg.sidx][63:32];
            else if (paddr == A_SATC)
                r_next.prdata = {24'h0, r_reg.sat[r_reg.sidx].flags};
        end
        else
        begin
            r_next.pslverr = 1'b0;
        end
        if (acc && pwrite && addr_ok(paddr))
        begin
            if (paddr == A_CTRL)
            begin
                r_next.pend_base = r_reg.pend_base | pwdata[0];
                r_next.pend_sat = r_reg.pend_sat | pwdata[1];
            end
            else if (paddr == A_STAT)
            begin
                r_next.zav_new = r_reg.zav_new & ~pwdata[1];
                r_next.zav_err = r_reg.zav_err & ~pwdata[2];
            end
            else if (paddr >= A_BASE0 && paddr < A_FIX)
                r_next.base[boff[5:2]] = pwdata;
            else if (paddr == A_FIX && pwdata <= 32'(FIX_MAX))
                r_next.fix = pwdata[2:0];
            else if (paddr == A_SCNT)
                r_next.scnt = (pwdata > 32'(MAX_SATS)) ? MAX_SATS : pwdata[6:0];
            else if (paddr == A_SIDX)
                r_next.sidx = pwdata[5:0];
            else if (paddr == A_SATA)
            begin
                r_next.sat[r_reg.sidx].sys = fsys;
                r_next.sat[r_reg.sidx].prn = pwdata[15:8];
                r_next.sat[r_reg.sidx].freq = freq_chk(fsys[2:0], pwdata[23:16]);
                r_next.sat[r_reg.sidx].elev = pwdata[31:24];
            end
            else if (paddr == A_SATB)
                r_next.sat[r_reg.sidx][63:32] = pwdata;
            else if (paddr == A_SATC)
                r_next.sat[r_reg.sidx].flags = {4'h0, pwdata[3:0]};
        end
        // Hardware events land after the software clear, so a set wins.
        if (zav_stb)
        begin
            r_next.zav = zav_dur;
            r_next.zav_new = 1'b1;
        end
        if (zav_err_stb)
            r_next.zav_err = 1'b1;

        // Packet sequencer. Software should not rewrite the table while a
        // satellite epoch is in flight; the bytes are read as they go out.
        unique case (r_reg.st)
            ST_IDLE:
            begin
                if (r_reg.pend_base)
                begin
                    r_next.pend_base = 1'b0;
                    r_next.is_sat = 1'b0;
                    r_next.st = ST_ID;
                end
                else if (r_reg.pend_sat)
                begin
                    r_next.pend_sat = 1'b0;
                    r_next.is_sat = 1'b1;
                    r_next.remain = r_reg.scnt;
                    r_next.ridx = 6'h00;
                    r_next.seq = 2'h1;
                    r_next.total = (r_reg.scnt == 7'h00) ? 2'h1 :
                        2'((8'(r_reg.scnt) + 8'(MAX_PER_PKT) - 8'h01) / 8'(MAX_PER_PKT));
                    r_next.st = ST_ID;
                end
            end
            ST_ID:
            begin
                if (push)
                    r_next.st = ST_LEN;
            end
            ST_LEN:
            begin
                if (push)
                begin
                    r_next.st = ST_PAY;
                    r_next.bcnt = 6'h00;
                    r_next.rj = 4'h0;
                    r_next.pleft = pn;
                end
            end
            ST_PAY:
            begin
                if (push)
                begin
                    if (r_reg.is_sat && r_reg.bcnt >= 6'h02)
                    begin
                        if (r_reg.rj == REC_LAST[3:0])
                        begin
                            r_next.rj = 4'h0;
                            r_next.ridx = 6'(r_reg.ridx + 6'h01);
                            r_next.pleft = 5'(r_reg.pleft - 5'h01);
                            r_next.remain = 7'(r_reg.remain - 7'h01);
                        end
                        else
                            r_next.rj = 4'(r_reg.rj + 4'h1);
                    end
                    else
                        r_next.bcnt = 6'(r_reg.bcnt + 6'h01);
                    if (olast)
                    begin
                        if (r_reg.is_sat && r_reg.seq < r_reg.total)
                        begin
                            r_next.seq = 2'(r_reg.seq + 2'h1);
                            r_next.st = ST_ID;
                        end
                        else
                            r_next.st = ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    //////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_base_length: assert property (
        (r_reg.st == ST_LEN && !r_reg.is_sat && push) |-> ob == 8'h2D)
        else $error("base report length byte wrong");
    a_rel_offset: assert property (
        (r_reg.st == ST_PAY && !r_reg.is_sat && push && r_reg.bcnt == 6'h24)
        |-> ob == r_reg.base[9][7:0])
        else $error("east offset not at byte 36");
    a_fix_last: assert property (
        (r_reg.st == ST_PAY && !r_reg.is_sat && push && r_reg.bcnt == 6'h2C)
        |-> (ob == {5'h00, r_reg.fix} && olast) ##1 r_reg.st == ST_IDLE)
        else $error("fix byte not last of base report");
    a_zav_capture: assert property (
        zav_stb |=> (r_reg.zav == $past(zav_dur) && r_reg.zav_new))
        else $error("duration not captured");
    a_sat_ident: assert property (
        (r_reg.st == ST_ID && r_reg.is_sat && push) |-> ob == 8'h54)
        else $error("satellite report identifier wrong");
    a_seq_range: assert property (
        (r_reg.st == ST_PAY && r_reg.is_sat && push && r_reg.bcnt == 6'h01)
        |-> (ob != 8'h00 && ob <= {6'h00, r_reg.total}))
        else $error("sequence number out of range");
    a_rec_cap: assert property (
        (r_reg.st == ST_PAY && r_reg.is_sat) |-> r_reg.pleft <= 5'd28)
        else $error("too many records in one report");
    a_seq_step: assert property (
        (r_reg.st == ST_PAY && r_reg.is_sat && push && olast && r_reg.seq < r_reg.total)
        |=> (r_reg.st == ST_ID && r_reg.seq == 2'($past(r_reg.seq) + 2'h1)))
        else $error("sequence did not advance by one");
    a_multi_total: assert property (
        (r_reg.st == ST_ID && r_reg.is_sat && r_reg.seq == 2'h1 && r_reg.remain > 7'd28)
        |-> r_reg.total > 2'h1)
        else $error("large epoch sent as one report");
    a_sys_code: assert property (
        (r_reg.st == ST_PAY && r_reg.is_sat && push && r_reg.bcnt == 6'h02
        && r_reg.rj == 4'h0) |-> ob <= 8'h06)
        else $error("reserved system code sent");
    a_freq_code: assert property (
        (r_reg.st == ST_PAY && r_reg.is_sat && push && r_reg.bcnt == 6'h02
        && r_reg.rj == 4'h2) |-> ob <= 8'h0A)
        else $error("frequency code out of range");
    a_flag_byte: assert property (
        (r_reg.st == ST_PAY && r_reg.is_sat && push && r_reg.bcnt == 6'h02
        && r_reg.rj == 4'h8) |-> ob[7:4] == 4'h0)
        else $error("reserved flag bits set");

    c_base_sent: cover property (r_reg.st == ST_PAY && !r_reg.is_sat && push && olast);
    c_multi_epoch: cover property (r_reg.is_sat && r_reg.seq == 2'h2 && r_reg.st == ST_ID);
    c_zav_taken: cover property (zav_stb);
    c_tx_stall: cover property (r_reg.st != ST_IDLE && !f_ready);
endmodule

// ===== nspf_host.sv
`timescale 1ns/1ns
module nspf_host
(
    input wire logic pclk,
    input wire logic slow,
    output logic tx_ready,
    output logic rx_valid,
    output logic rx_sop,
    output logic rx_eop,
    output logic [7:0] rx_data
);
    logic [1:0] cnt = 2'h0;
    initial
    begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_sop = 1'b0;
        rx_eop = 1'b0;
        rx_data = 8'hA5;
    end
    // A slow host takes one byte in four, so the small buffer fills and refuses.
    always @(posedge pclk)
    begin
        cnt <= cnt + 2'h1;
        tx_ready <= !slow || cnt == 2'h0;
    end
    task automatic send(input logic [31:0] dur, input logic [31:0] rsv);
        logic [79:0] pk;
        pk = {rsv, dur, 8'h08, 8'h53};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_sop <= i == 0;
            rx_eop <= i == 9;
            rx_data <= pk[8*i+:8];
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_sop <= 1'b0;
        rx_eop <= 1'b0;
        // The line no longer holds the last byte once the packet is over.
        rx_data <= ~pk[79:72];
    endtask
endmodule

// ===== nspf_top_bench.sv
`timescale 1ns/1ns
module nspf_top_bench;
    import nspf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, rx_valid, rx_sop, rx_eop, tx_valid, tx_last, tx_ready;
    logic slow = 1'b0;
    logic [7:0] rx_data, tx_data;
    logic [31:0] seed = 32'h0000_8E73;
    logic [31:0] rd;
    logic er;
    logic [8:0] q[$];
    nspf_rec_t rec[30];
    int error_cnt = 0;
    int num_checks = 0;
    nspf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_sop(rx_sop), .rx_eop(rx_eop),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready));
    nspf_host host (.pclk(pclk), .slow(slow), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_sop(rx_sop), .rx_eop(rx_eop), .rx_data(rx_data));
    initial
    begin
        forever #50 pclk = ~pclk;
    end
    //////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic push(input logic [7:0] b, input logic l);
        q.push_back({l, b});
    endtask
    task automatic drain(input string n);
        for (int i = 0; i < 5000 && q.size() != 0; i++) @(posedge pclk);
        chk("bytes left", 0, q.size());
        $display("test %s done", n);
    endtask
    // Every byte taken by the host is held against the oldest expectation.
    always @(posedge pclk)
    begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
            if (q.size() == 0)
                chk("spare byte", 0, 1);
            else
                chk("tx byte", {23'h0, q.pop_front()}, {23'h0, tx_last, tx_data});
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #6000000;
        error_cnt++;
        tally_and_finish;
    end
    //////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [351:0] base;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_FIX, 32'h0);
        chk("fix reset", 0, rd);
        apb(1'b0, 8'h80, 32'h0);
        chk("unmapped err", 1, er);
        $display("test reset done");
        for (int w = 0; w < NBASE; w++)
        begin
            seed = lfsr(seed);
            base[32*w+:32] = seed;
            apb(1'b1, A_BASE0 + 8'(4 * w), seed);
        end
        for (int f = 0; f < 8; f++)
        begin
            apb(1'b1, A_FIX, 32'(f));
            apb(1'b1, A_FIX, 32'h8);
            apb(1'b1, A_CTRL, 32'h1);
            push(8'h50, 1'b0);
            push(8'h2D, 1'b0);
            for (int k = 0; k < 44; k++) push(base[8*k+:8], 1'b0);
            push(8'(f), 1'b1);
            apb(1'b0, A_STAT, 32'h0);
            chk("busy", 1, rd & 32'h1);
            drain("base");
        end
        host.send(32'h3F80_0000, 32'h0);
        repeat (3) @(posedge pclk);
        apb(1'b0, A_STAT, 32'h0);
        chk("zav new", 32'h2, rd & 32'h6);
        apb(1'b0, A_ZAV, 32'h0);
        chk("zav dur", 32'h3F80_0000, rd);
        apb(1'b1, A_STAT, 32'h6);
        host.send(32'h4000_0000, 32'h0100_0000);
        repeat (3) @(posedge pclk);
        apb(1'b0, A_STAT, 32'h0);
        chk("zav err", 32'h4, rd & 32'h6);
        $display("test zav done");
        apb(1'b1, A_SCNT, 32'd30);
        for (int i = 0; i < 30; i++)
        begin
            seed = lfsr(seed);
            rec[i] = {seed[7:0], seed[15:8], seed[23:16], seed[31:16], seed[15:8],
                8'(i != 8 && i != 7), seed[23:16], 8'(i != 7)};
            apb(1'b1, A_SIDX, 32'(i));
            // An unknown system has no defined frequency, so code 1 must turn to 0 there.
            apb(1'b1, A_SATA, {rec[i].elev, (i == 8) ? 8'h09 : 8'h01, rec[i].prn,
                (i == 7) ? 8'h09 : 8'h01});
            apb(1'b1, A_SATB, {rec[i].snr2, rec[i].snr1, rec[i].az});
            apb(1'b1, A_SATC, {24'h0, rec[i].flags});
            rec[i].flags[7:4] = 4'h0;
        end
        slow <= 1'b1;
        apb(1'b1, A_CTRL, 32'h2);
        for (int p = 0; p < 2; p++)
        begin
            push(8'h54, 1'b0);
            push(p ? 8'd20 : 8'd254, 1'b0);
            push(8'h02, 1'b0);
            push(8'(p + 1), 1'b0);
            for (int k = 0; k < (p ? 18 : 252); k++)
                push(rec[28 * p + k / 9][8*(k%9)+:8], k == (p ? 17 : 251));
        end
        drain("satellites");
        tally_and_finish;
    end
endmodule
